// ===== hdl/rx_mac_datapath.sv
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// - Filter control bit 0 selects cut-through.
// - Filter control bit 3 enables runt dropping.
// - Cut-through buffers until 64 bytes; only runts filtered.
// - Cut-through skips address filtering, promiscuous.
// - Invalid frames follow enabled filters only.
// - Max 9600: pass up to 9644, flag beyond; dropped only with oversize filter on, not in cut-through.
// - 100G variant tolerates 44 bytes over maximum.
// - 40G variant tolerates 20 bytes over maximum.
// - Filters: address, runt, oversize, pause, control, FCS.
// - Start, six preamble, SFD checked; else ignored.
// - Start byte sits in most significant lane.
// - Byte d5 is the delimiter.
// - Preamble stripped unless pass-through bit set.
// - CRC config bit 1 removes FCS, reset on.
// - Removal works for every client width.
// - End marker on last kept byte.
// - FCS error raised with end marker.
// - CRC bits taken LSB first per byte.
// - Bad CRC sets error, valid, error bit 1.
// - FCS result reaches the client with every delivered frame.
module rx_mac_datapath
   import rx_mac_pkg::*;
#(
   parameter int GBPS = 100,
   parameter int DEPTH = 2048
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic resetn,
   // Register port.
   input wire reg_req_t reg_req,
   output logic [31:0] reg_rdata,
   // Line side stream.
   input wire beat_t phy_in,
   // Client side stream.
   output beat_t client_out,
   output logic client_fcs_valid
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [15:0] SLACK = (GBPS == 40) ? SLACK_40G : SLACK_100G;

   typedef logic [AW:0] ptr_t;

   typedef struct packed {
      logic [FILT_BITS-1:0] filt;
      logic pass;
      logic crc_rm;
      logic am_en;
      logic am_filt;
      logic [47:0] da;
      logic [15:0] max_len;
      logic [15:0] n_drop;
      logic [15:0] n_ok;
      logic [31:0] rdata;
      logic in_frame;
      logic skip;
      logic first;
      logic started;
      logic [15:0] len;
      logic [1:0] widx;
      logic [31:0] crc;
      logic [47:0] rx_da;
      logic [31:0] rx_type;
      logic hv;
      word_t held;
      logic hkeep;
      logic ov;
      ptr_t wp;
      ptr_t fsp;
      ptr_t cp;
      ptr_t rp;
      beat_t out;
   } state_t;

   state_t s;
   state_t next_s;
   word_t mem [DEPTH];
   logic we;
   logic mem_we;
   logic full;
   logic wkeep;
   word_t wword;
   logic push;
   logic fold;
   word_t pw;
   logic pkeep;
   logic [3:0] nb;
   logic [15:0] flen;
   logic [31:0] crc_n;
   logic runt;
   logic over;
   logic fcs_bad;
   logic ctrl;
   logic pause;
   logic mism;
   logic drop;
   logic [2:0] err;
   ptr_t limit;

   // Bytes go in lane order, each fed low bit first, so the first FCS bit is the top coefficient.
   function automatic logic [31:0] crc_word(input logic [31:0] c_in, input logic [63:0] d, input logic [3:0] n);
      logic [31:0] c;
      logic [7:0] b;
      c = c_in;
      for (int i = 0; i < 8; i++) begin
         b = d[63-8*i -: 8];
         if (4'(i) < n) begin
            for (int k = 0; k < 8; k++) begin
               c = (c >> 1) ^ ((c[0] ^ b[k]) ? CRC_POLY : 32'h0000_0000);
            end
         end
      end
      return c;
   endfunction : crc_word

   always_comb begin
      next_s = s;
      we = 1'b0;
      wword = '0;
      wkeep = 1'b0;
      push = 1'b0;
      fold = 1'b0;
      pw = phy_in.w;
      pw.err = 3'h0;
      pw.fcs_err = 1'b0;
      pw.eop = 1'b0;
      pkeep = 1'b1;
      nb = phy_in.w.eop ? 4'(LANES - {1'b0, phy_in.w.empty}) : LANES;
      flen = s.len + 16'(nb);
      crc_n = crc_word(s.crc, phy_in.w.data, nb);

      // Register port; reads answer in the following cycle only.
      next_s.rdata = 32'h0000_0000;
      if (reg_req.wr) begin
         unique case (reg_req.addr)
            REG_FILTER_CTRL: next_s.filt = reg_req.wdata[FILT_BITS-1:0];
            REG_MAX_LEN: next_s.max_len = reg_req.wdata[15:0];
            REG_PREAMBLE_PASS: next_s.pass = reg_req.wdata[F_PASS];
            REG_CRC_CFG: next_s.crc_rm = reg_req.wdata[F_CRC_REMOVE];
            REG_ADDR_MATCH: begin
               next_s.am_en = reg_req.wdata[F_AM_EN];
               next_s.am_filt = reg_req.wdata[F_AM_FILT];
            end
            REG_DA_LO: next_s.da[31:0] = reg_req.wdata;
            REG_DA_HI: next_s.da[47:32] = reg_req.wdata[15:0];
            default: ;
         endcase
      end
      if (reg_req.rd) begin
         unique case (reg_req.addr)
            REG_FILTER_CTRL: next_s.rdata = 32'(s.filt);
            REG_MAX_LEN: next_s.rdata = 32'(s.max_len);
            REG_STATUS: next_s.rdata = {s.n_drop, s.n_ok};
            REG_PREAMBLE_PASS: next_s.rdata = 32'(s.pass);
            REG_CRC_CFG: next_s.rdata = {30'h0, s.crc_rm, 1'b0};
            REG_ADDR_MATCH: next_s.rdata = {1'b0, s.am_filt, 29'h0, s.am_en};
            REG_DA_LO: next_s.rdata = s.da[31:0];
            REG_DA_HI: next_s.rdata = {16'h0000, s.da[47:32]};
            default: next_s.rdata = 32'h0000_0000;
         endcase
      end

      // Frame checks, evaluated on the word that ends the frame.
      next_s.rx_da = (s.widx == 2'h0) ? phy_in.w.data[63:16] : s.rx_da;
      next_s.rx_type = (s.widx == 2'h1) ? phy_in.w.data[31:0] : s.rx_type;
      runt = flen < MIN_LEN;
      over = flen > (s.max_len + SLACK);
      fcs_bad = crc_n != CRC_RESIDUE;
      ctrl = next_s.rx_type[31:16] == CTRL_TYPE;
      pause = ctrl && (next_s.rx_type[15:0] == PAUSE_OP);
      mism = s.am_en && s.am_filt && (next_s.rx_da != s.da);
      // Cut-through cannot take back words already sent, so only the runt test applies there.
      drop = (runt && s.filt[F_RUNT])
         || (!s.filt[F_CUT_THROUGH]
            && ((over && s.filt[F_OVERSIZE]) || (fcs_bad && s.filt[F_FCS_FILT])
               || (pause && s.filt[F_PAUSE]) || (ctrl && !pause && s.filt[F_CONTROL]) || mism));
      err = 3'h0;
      err[ERR_RUNT] = runt;
      err[ERR_FCS] = fcs_bad;
      err[ERR_OVERSIZE] = over;

      // Line side intake.
      if (phy_in.valid && phy_in.w.sop) begin
         next_s.in_frame = 1'b1;
         next_s.skip = phy_in.w.data != PREAMBLE_WORD;
         next_s.len = 16'h0000;
         next_s.widx = 2'h0;
         next_s.crc = CRC_INIT;
         next_s.started = 1'b0;
         next_s.ov = 1'b0;
         next_s.first = !s.pass;
         next_s.rx_da = s.rx_da;
         next_s.rx_type = s.rx_type;
         if (!next_s.skip && s.pass) begin
            push = 1'b1;
         end
      end else if (phy_in.valid && s.in_frame && !s.skip) begin
         next_s.crc = crc_n;
         next_s.len = flen;
         next_s.widx = (s.widx == 2'h3) ? s.widx : s.widx + 2'h1;
         next_s.first = 1'b0;
         pw.sop = s.first;
         if (s.filt[F_CUT_THROUGH] && flen >= MIN_LEN) begin
            next_s.started = 1'b1;
         end
         if (phy_in.w.eop) begin
            next_s.in_frame = 1'b0;
            if (s.crc_rm && nb <= FCS_LEN) begin
               fold = 1'b1;
            end else begin
               push = 1'b1;
               pw.eop = 1'b1;
               pw.empty = s.crc_rm ? 3'(phy_in.w.empty + 3'h4) : phy_in.w.empty;
               pw.err = err;
               pw.fcs_err = fcs_bad;
               pkeep = !drop;
            end
         end else begin
            push = 1'b1;
         end
      end else if (phy_in.valid && phy_in.w.eop) begin
         next_s.in_frame = 1'b0;
      end

      // One word of holding lets the FCS bytes be trimmed from the end.
      if (push) begin
         we = s.hv;
         wword = s.held;
         wkeep = s.hkeep;
         next_s.hv = 1'b1;
         next_s.held = pw;
         next_s.hkeep = pkeep;
      end else if (fold) begin
         we = s.hv;
         wword = s.held;
         wword.eop = 1'b1;
         wword.empty = 3'(FCS_LEN - nb);
         wword.err = err;
         wword.fcs_err = fcs_bad;
         wkeep = !drop;
         next_s.hv = 1'b0;
      end else if (s.hv && s.held.eop) begin
         we = 1'b1;
         wword = s.held;
         wkeep = s.hkeep;
         next_s.hv = 1'b0;
      end

      full = ptr_t'(s.wp - s.rp) == ptr_t'(DEPTH);
      mem_we = we && !full;
      if (we) begin
         if (!full) begin
            next_s.wp = s.wp + ptr_t'(1);
         end
         if (wword.eop) begin
            if (wkeep && !s.ov && !full) begin
               next_s.fsp = s.wp + ptr_t'(1);
               next_s.cp = s.wp + ptr_t'(1);
               next_s.n_ok = s.n_ok + 16'h0001;
            end else begin
               next_s.wp = s.fsp;
               next_s.n_drop = s.n_drop + 16'h0001;
            end
         end else if (full) begin
            next_s.ov = 1'b1;
         end
      end

      // Store-and-forward releases whole committed frames; cut-through follows the writer once safe.
      limit = (s.filt[F_CUT_THROUGH] && s.started) ? s.wp : s.cp;
      next_s.out.valid = s.rp != limit;
      next_s.out.w = s.out.w;
      if (s.rp != limit) begin
         next_s.out.w = mem[s.rp[AW-1:0]];
         next_s.rp = s.rp + ptr_t'(1);
      end
   end

   always_ff @(posedge clk) begin
      if (mem_we) begin
         mem[s.wp[AW-1:0]] <= wword;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         s <= '0;
         s.filt <= FILTER_RST;
         s.crc_rm <= CRC_REMOVE_RST;
         s.max_len <= MAX_LEN_RST;
         s.crc <= CRC_INIT;
      end else begin
         s <= next_s;
      end
   end

   assign reg_rdata = s.rdata;
   assign client_out = s.out;
   assign client_fcs_valid = s.out.valid && s.out.w.eop;
endmodule : rx_mac_datapath
`default_nettype wire

// ===== hdl/rx_mac_pkg.sv
`default_nettype none
package rx_mac_pkg;
   // Register addresses.
   localparam logic [15:0] REG_FILTER_CTRL = 16'h0103;
   localparam logic [15:0] REG_MAX_LEN = 16'h0104;
   localparam logic [15:0] REG_STATUS = 16'h0105;
   localparam logic [15:0] REG_PREAMBLE_PASS = 16'h0125;
   localparam logic [15:0] REG_CRC_CFG = 16'h0126;
   localparam logic [15:0] REG_ADDR_MATCH = 16'h0140;
   localparam logic [15:0] REG_DA_LO = 16'h0141;
   localparam logic [15:0] REG_DA_HI = 16'h0142;
   // Field positions.
   localparam int F_CUT_THROUGH = 0;
   localparam int F_OVERSIZE = 1;
   localparam int F_FCS_FILT = 2;
   localparam int F_RUNT = 3;
   localparam int F_PAUSE = 4;
   localparam int F_CONTROL = 5;
   localparam int FILT_BITS = 6;
   localparam int F_PASS = 0;
   localparam int F_CRC_REMOVE = 1;
   localparam int F_AM_EN = 0;
   localparam int F_AM_FILT = 30;
   localparam int ERR_RUNT = 0;
   localparam int ERR_FCS = 1;
   localparam int ERR_OVERSIZE = 2;
   // Reset values.
   localparam logic [5:0] FILTER_RST = 6'h00;
   localparam logic CRC_REMOVE_RST = 1'b1;
   localparam logic [15:0] MAX_LEN_RST = 16'h2580;
   // Frame constants.
   localparam logic [63:0] PREAMBLE_WORD = 64'hfb55_5555_5555_55d5;
   localparam logic [31:0] CRC_POLY = 32'hedb8_8320;
   localparam logic [31:0] CRC_INIT = 32'hffff_ffff;
   localparam logic [31:0] CRC_RESIDUE = 32'hdebb_20e3;
   localparam logic [15:0] MIN_LEN = 16'h0040;
   localparam logic [3:0] FCS_LEN = 4'h4;
   localparam logic [3:0] LANES = 4'h8;
   localparam logic [15:0] CTRL_TYPE = 16'h8808;
   localparam logic [15:0] PAUSE_OP = 16'h0001;
   localparam logic [15:0] SLACK_100G = 16'h002c;
   localparam logic [15:0] SLACK_40G = 16'h0014;

   typedef struct packed {
      logic [63:0] data;
      logic sop;
      logic eop;
      logic [2:0] empty;
      logic fcs_err;
      logic [2:0] err;
   } word_t;

   typedef struct packed {
      logic valid;
      word_t w;
   } beat_t;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [15:0] addr;
      logic [31:0] wdata;
   } reg_req_t;
endpackage : rx_mac_pkg
`default_nettype wire

// ===== sim/rx_mac_chk.sv
`timescale 1ns/100ps
`default_nettype none
module rx_mac_chk
   import rx_mac_pkg::*;
(
   // Clock and reset.
   input wire logic clk,
   input wire logic resetn,
   // Observed ports.
   input wire reg_req_t reg_req,
   input wire logic [31:0] reg_rdata,
   input wire beat_t phy_in,
   input wire beat_t client_out,
   input wire logic client_fcs_valid
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   sequence s_last;
      client_out.valid && client_out.w.eop;
   endsequence
   sequence s_mid;
      client_out.valid && !client_out.w.eop;
   endsequence
   fcs_valid_a: assert property (client_fcs_valid == (client_out.valid && client_out.w.eop))
      else $error("fcs valid not tied to end of frame");
   fcs_err_eop_a: assert property (client_out.valid && client_out.w.fcs_err |-> client_out.w.eop)
      else $error("fcs error away from end of frame");
   err_bit_a: assert property (s_last and client_out.w.fcs_err |-> client_out.w.err[ERR_FCS])
      else $error("fcs error without error bit");
   next_sop_a: assert property (s_last ##1 client_out.valid |-> client_out.w.sop)
      else $error("frame after end lacks start");
   first_sop_a: assert property ($rose(client_out.valid) |-> client_out.w.sop)
      else $error("first word lacks start");
   gapless_a: assert property (s_mid |=> client_out.valid)
      else $error("gap inside client frame");
   empty_mid_a: assert property (s_mid |-> client_out.w.empty == 3'h0)
      else $error("empty lanes before end");
   rdata_idle_a: assert property (!$past(reg_req.rd) |-> reg_rdata == 32'h0)
      else $error("read data outside read slot");
   unmapped_a: assert property ($past(reg_req.rd) && $past(reg_req.addr) == 16'h0100 |-> reg_rdata == 32'h0)
      else $error("unmapped read not zero");
endmodule : rx_mac_chk
`default_nettype wire

// ===== sim/phy_model.sv
`timescale 1ns/100ps
`default_nettype none
module phy_model
   import rx_mac_pkg::*;
(
   // Clock.
   input wire logic clk,
   // Line side.
   output beat_t phy_in
);
   initial phy_in = '0;
   function automatic logic [31:0] crc_b(logic [31:0] c, logic [7:0] b);
      c = c ^ {24'h0, b};
      for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ CRC_POLY : c >> 1;
      return c;
   endfunction : crc_b
   // Sends n bytes from address to check sequence; byte i before the check sequence carries i.
   task automatic send(input int n, input bit bad_crc, input bit bad_pre);
      logic [7:0] fr[$];
      logic [31:0] c;
      logic [63:0] d;
      int i;
      c = CRC_INIT;
      for (i = 0; i < n - 4; i++) begin
         fr.push_back(i[7:0]);
         c = crc_b(c, i[7:0]);
      end
      c = ~c ^ {31'h0, bad_crc};
      for (i = 0; i < 4; i++) fr.push_back(c[8 * i +: 8]);
      @(posedge clk);
      phy_in <= '{valid: 1'b1, w: '{data: PREAMBLE_WORD ^ {63'h0, bad_pre}, sop: 1'b1, default: '0}};
      for (i = 0; i < n; i += 8) begin
         for (int b = 0; b < 8; b++) d[63 - 8 * b -: 8] = (i + b < n) ? fr[i + b] : 8'h00;
         @(posedge clk);
         phy_in <= '{valid: 1'b1, w: '{data: d, eop: i + 8 >= n, empty: (i + 8 >= n) ? 3'(i + 8 - n) : 3'h0,
                    default: '0}};
      end
      @(posedge clk);
      // A released line shows inverted data, so a stale word is never taken for a fresh one.
      phy_in <= '{valid: 1'b0, w: '{data: ~d, default: '0}};
   endtask : send
endmodule : phy_model
`default_nettype wire

// ===== sim/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
   import rx_mac_pkg::*;
   logic clk;
   logic resetn;
   reg_req_t reg_req;
   logic [31:0] reg_rdata;
   beat_t phy_in;
   beat_t client_out;
   logic client_fcs_valid;
   int bad_count = 0;
   int n_checks = 0;
   int frames = 0;
   int nbytes = 0;
   logic [7:0] first;
   logic [2:0] lerr;
   logic lfcs;
   logic lfv;
   rx_mac_datapath #(.GBPS(100), .DEPTH(64)) uut (.clk(clk), .resetn(resetn), .reg_req(reg_req),
      .reg_rdata(reg_rdata), .phy_in(phy_in), .client_out(client_out), .client_fcs_valid(client_fcs_valid));
   phy_model phy (.clk(clk), .phy_in(phy_in));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      if (client_out.valid === 1'b1) begin
         if (client_out.w.sop) begin
            first <= client_out.w.data[63:56];
         end
         nbytes <= (client_out.w.sop ? 0 : nbytes) + (client_out.w.eop ? 8 - int'(client_out.w.empty) : 8);
         if (client_out.w.eop) begin
            lerr <= client_out.w.err;
            lfcs <= client_out.w.fcs_err;
            lfv <= client_fcs_valid;
            frames <= frames + 1;
         end
      end
   end
   task automatic print_verdict();
      $display("checks %0d, errors %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : print_verdict
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value %s: expected %h, seen %h", what, exp, got);
      end
   endtask : chk
   task automatic wr(input logic [15:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge clk);
      reg_req <= '0;
   endtask : wr
   task automatic rd(input logic [15:0] a, input logic [31:0] exp, input string what);
      @(posedge clk);
      reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
      @(posedge clk);
      reg_req <= '0;
      #1 chk(what, exp, reg_rdata);
   endtask : rd
   // A negative length means the frame must not reach the client.
   task automatic frame(input int n, input bit bc, input bit bp, input int exp_n, input logic [7:0] f, input logic e);
      int f0;
      int k;
      f0 = frames;
      phy.send(n, bc, bp);
      for (k = 0; k < 60 && frames == f0; k++) @(posedge clk);
      #1;
      if (exp_n < 0) chk("dropped", f0, frames);
      else begin
         chk("frames", f0 + 1, frames);
         if (frames == f0) print_verdict();
         chk("length", exp_n, nbytes);
         chk("first byte", f, first);
         chk("fcs error", e, lfcs);
         chk("error bit", e, lerr[ERR_FCS]);
         chk("fcs valid", 1, lfv);
      end
   endtask : frame
   initial begin
      resetn = 1'b0;
      reg_req = '0;
      repeat (8) @(posedge clk);
      resetn <= 1'b1;
      rd(REG_CRC_CFG, 32'h0000_0002, "crc config");
      rd(REG_FILTER_CTRL, 32'h0000_0000, "filter control");
      rd(16'h0100, 32'h0000_0000, "unmapped");
      frame(64, 0, 0, 60, 8'h00, 0);
      frame(67, 1, 0, 63, 8'h00, 1);
      frame(64, 0, 1, -1, 8'h00, 0);
      wr(REG_CRC_CFG, 32'h0000_0000);
      frame(64, 0, 0, 64, 8'h00, 0);
      wr(REG_CRC_CFG, 32'h0000_0002);
      wr(REG_PREAMBLE_PASS, 32'h0000_0001);
      frame(64, 0, 0, 68, PREAMBLE_WORD[63:56], 0);
      wr(REG_PREAMBLE_PASS, 32'h0000_0000);
      wr(REG_FILTER_CTRL, 32'h0000_0008);
      frame(60, 0, 0, -1, 8'h00, 0);
      wr(REG_FILTER_CTRL, 32'h0000_000c);
      frame(67, 1, 0, -1, 8'h00, 1);
      wr(REG_FILTER_CTRL, 32'h0000_000d);
      rd(REG_FILTER_CTRL, 32'h0000_000d, "filter control");
      frame(60, 0, 0, -1, 8'h00, 0);
      frame(67, 1, 0, 63, 8'h00, 1);
      wr(REG_FILTER_CTRL, 32'h0000_0002);
      wr(REG_MAX_LEN, 32'h0000_0064);
      frame(144, 0, 0, 140, 8'h00, 0);
      frame(145, 0, 0, -1, 8'h00, 0);
      // The model's frames carry byte i at position i, so the destination is 00_01_02_03_04_05.
      wr(REG_DA_LO, 32'h0203_0405);
      wr(REG_DA_HI, 32'h0000_0001);
      wr(REG_ADDR_MATCH, 32'h4000_0001);
      frame(64, 0, 0, 60, 8'h00, 0);
      wr(REG_DA_LO, 32'h0203_0406);
      frame(64, 0, 0, -1, 8'h00, 0);
      wr(REG_FILTER_CTRL, 32'h0000_0001);
      frame(64, 0, 0, 60, 8'h00, 0);
      rd(REG_STATUS, 32'h0005_0008, "status");
      @(posedge clk);
      resetn <= 1'b0;
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
      rd(REG_FILTER_CTRL, 32'h0000_0000, "filter control");
      rd(REG_CRC_CFG, 32'h0000_0002, "crc config");
      rd(REG_STATUS, 32'h0000_0000, "status");
      print_verdict();
   end
endmodule : tb
bind rx_mac_datapath rx_mac_chk chk (.clk(clk), .resetn(resetn), .reg_req(reg_req), .reg_rdata(reg_rdata),
   .phy_in(phy_in), .client_out(client_out), .client_fcs_valid(client_fcs_valid));
`default_nettype wire
